/* src/dbm_pkg.sv */
// constants for the dual byte match timer
package dbm_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CTRL  = 16'hFE18;
  localparam logic [15:0] IDX_PRESC = 16'hFE19;
  localparam logic [15:0] IDX_LCNT  = 16'hFE1A;
  localparam logic [15:0] IDX_HCNT  = 16'hFE1B;
  localparam logic [15:0] IDX_LMD   = 16'hFE1C;
  localparam logic [15:0] IDX_HMD   = 16'hFE1D;
  localparam logic [15:0] IDX_ISTAT = 16'hFE20;
  localparam logic [15:0] IDX_ICLR  = 16'hFE21;
  localparam logic [15:0] IDX_IEN   = 16'hFE22;
  // timer_control_flags field positions
  localparam int CTRL_HRUN  = 7;
  localparam int CTRL_LRUN  = 6;
  localparam int CTRL_CASC  = 5;
  localparam int CTRL_OMODE = 4;
  localparam int CTRL_HFLAG = 3;
  localparam int CTRL_HIE   = 2;
  localparam int CTRL_LFLAG = 1;
  localparam int CTRL_LIE   = 0;
  // prescale_select: high nibble at 4, low nibble at 0
  localparam int PRESC_HLSB = 4;
  localparam int PRESC_LLSB = 0;
  localparam int PRESC_EN   = 3;
  // bit position of each channel in status and enable
  localparam int EV_LOW  = 0;
  localparam int EV_HIGH = 1;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] BYTE_MAX  = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLV  = 2'h2;
endpackage

/* src/dbm_timer.sv */
// dual byte match timer with axi4-lite register slave
// Contract
// RQ1: high flag and enable raise vector request
// RQ2: low flag and enable raise vector request
// RQ3: low flag sets when running low reaches zero
// RQ4: flags clear only by software writing zero
// RQ5: prescaler change waits for buffer reload
// RQ6: high prescaler divides 1 or 2 to 256
// RQ7: low prescaler divides 1 or 2 to 256
// RQ8: low counter counts prescaler pulses, read only
// RQ9: high counter counts prescaler pulses, read only
// RQ10: low match when count equals buffer
// RQ11: low buffer follows data, reloads at zero
// RQ12: high match when count equals buffer
// RQ13: high buffer follows data, reloads at zero
// RQ14: run bit zero stops counter at zero
// RQ15: cascade advances high once per low period
// RQ16: match resets counters in listed modes
// RQ17: low output toggles or pwm, high when stopped
// RQ18: high flag sets when running high reaches zero
`timescale 1ns/1ps
module dbm_timer #(
  parameter int ADDR_W = 18
) (
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   low_wave_out,
  output logic                   high_wave_out,
  output logic                   match_irq_req,
  output logic                   irq
);
  if (ADDR_W < 18) begin : g_chk
    $error("ADDR_W too small for register indices");
  end

  // =====================================================
  // register bus slave
  logic              aw_got_q;
  logic              w_got_q;
  logic [15:0]       aw_idx_q;
  logic [7:0]        wdat_q;
  logic              wstb_q;
  logic              do_wr;
  logic              wr_hit;
  logic              ar_hs;
  logic [7:0]        rd_byte;
  logic              rd_hit;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  assign do_wr = aw_got_q && w_got_q && !bvalid_q;
  assign ar_hs = s_axi_arvalid && arready_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      aw_got_q  <= 1'b0;
      aw_idx_q  <= 16'h0000;
      awready_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        aw_got_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[17:2];
      end else if (do_wr) begin
        aw_got_q <= 1'b0;
      end
      awready_q <= !((s_axi_awvalid && awready_q) || (aw_got_q && !do_wr));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      w_got_q  <= 1'b0;
      wdat_q   <= dbm_pkg::RST_BYTE;
      wstb_q   <= 1'b0;
      wready_q <= 1'b0;
    end else begin
      if (s_axi_wvalid && wready_q) begin
        w_got_q <= 1'b1;
        wdat_q  <= s_axi_wdata[7:0];
        wstb_q  <= s_axi_wstrb[0];
      end else if (do_wr) begin
        w_got_q <= 1'b0;
      end
      wready_q <= !((s_axi_wvalid && wready_q) || (w_got_q && !do_wr));
    end
  end

  always_comb begin
    wr_hit = (aw_idx_q >= dbm_pkg::IDX_CTRL && aw_idx_q <= dbm_pkg::IDX_HMD)
          || (aw_idx_q >= dbm_pkg::IDX_ISTAT && aw_idx_q <= dbm_pkg::IDX_IEN);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= dbm_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? dbm_pkg::RESP_OKAY : dbm_pkg::RESP_SLV;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // writes with byte lane 0 off still answer but store nothing
  logic wr_ctrl;
  logic wr_presc;
  logic wr_lmd;
  logic wr_hmd;
  logic wr_iclr;
  logic wr_ien;
  assign wr_ctrl  = do_wr && wstb_q && aw_idx_q == dbm_pkg::IDX_CTRL;
  assign wr_presc = do_wr && wstb_q && aw_idx_q == dbm_pkg::IDX_PRESC;
  assign wr_lmd   = do_wr && wstb_q && aw_idx_q == dbm_pkg::IDX_LMD;
  assign wr_hmd   = do_wr && wstb_q && aw_idx_q == dbm_pkg::IDX_HMD;
  assign wr_iclr  = do_wr && wstb_q && aw_idx_q == dbm_pkg::IDX_ICLR;
  assign wr_ien   = do_wr && wstb_q && aw_idx_q == dbm_pkg::IDX_IEN;

  // =====================================================
  // software registers
  logic [7:0] presc_q;
  logic       casc_q;
  logic       omode_q;
  logic [1:0] ien_q;
  logic [1:0] stat_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      presc_q <= dbm_pkg::RST_BYTE;
      casc_q  <= 1'b0;
      omode_q <= 1'b0;
      ien_q   <= 2'h0;
    end else begin
      if (wr_presc) presc_q <= wdat_q;
      if (wr_ctrl) begin
        casc_q  <= wdat_q[dbm_pkg::CTRL_CASC];
        omode_q <= wdat_q[dbm_pkg::CTRL_OMODE];
      end
      if (wr_ien) ien_q <= wdat_q[1:0];
    end
  end

  // =====================================================
  // two counter channels, 0 low and 1 high
  logic [7:0] cnt_q  [2];
  logic [7:0] pre_q  [2];
  logic [7:0] mbuf_q [2];
  logic [7:0] md_q   [2];
  logic [3:0] act_q  [2];
  logic       run_q  [2];
  logic       ie_q   [2];
  logic       flag_q [2];
  logic       wave_q [2];
  wire  [1:0] inc;
  wire  [1:0] tick;
  wire  [1:0] match;
  wire  [1:0] zero;
  wire  [1:0] ovf;
  wire  [1:0] rst_m;
  wire  [1:0] pwm;

  // cascade: high prescaler sees one pulse per low period
  assign inc[0]   = 1'b1;
  assign inc[1]   = casc_q ? zero[0] : 1'b1; // RQ15
  // match reset in modes 0,2 (low) and 0,2,3 (high)
  assign rst_m[0] = !omode_q; // RQ16
  assign rst_m[1] = !(omode_q && !casc_q); // RQ16
  assign pwm[0]   = omode_q;
  assign pwm[1]   = omode_q && !casc_q;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    localparam int RUN_B  = c ? dbm_pkg::CTRL_HRUN : dbm_pkg::CTRL_LRUN;
    localparam int IE_B   = c ? dbm_pkg::CTRL_HIE : dbm_pkg::CTRL_LIE;
    localparam int FLAG_B = c ? dbm_pkg::CTRL_HFLAG : dbm_pkg::CTRL_LFLAG;
    localparam int PLSB   = c ? dbm_pkg::PRESC_HLSB : dbm_pkg::PRESC_LLSB;
    logic [7:0] lim;
    logic [7:0] nxt;
    logic       md_wr;
    // enable off divides by one, else 2 shifted by the code
    assign lim = act_q[c][dbm_pkg::PRESC_EN]
               ? 8'((9'h002 << act_q[c][2:0]) - 9'h001) : 8'h00; // RQ6 RQ7
    assign tick[c]  = run_q[c] && inc[c] && pre_q[c] == lim;
    assign match[c] = cnt_q[c] == mbuf_q[c]; // RQ10 RQ12
    assign nxt      = (match[c] && rst_m[c]) ? 8'h00 : cnt_q[c] + 8'h01;
    assign zero[c]  = tick[c] && nxt == 8'h00;
    assign ovf[c]   = tick[c] && cnt_q[c] == dbm_pkg::BYTE_MAX;
    assign md_wr    = c ? wr_hmd : wr_lmd;

    always_ff @(posedge clk_sys) begin
      if (!resetn || !run_q[c]) begin
        pre_q[c] <= 8'h00;
        cnt_q[c] <= 8'h00; // RQ14
      end else begin
        if (inc[c]) pre_q[c] <= tick[c] ? 8'h00 : pre_q[c] + 8'h01;
        if (tick[c]) cnt_q[c] <= nxt; // RQ8 RQ9
      end
    end

    // prescale and match value only change at a zero while running,
    // so a period in progress never sees a half-updated setting
    always_ff @(posedge clk_sys) begin
      if (!resetn) begin
        mbuf_q[c] <= dbm_pkg::RST_BYTE;
        act_q[c]  <= 4'h0;
      end else if (!run_q[c] || zero[c]) begin
        mbuf_q[c] <= md_q[c]; // RQ11 RQ13
        act_q[c]  <= presc_q[PLSB +: 4]; // RQ5
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!resetn) begin
        md_q[c]  <= dbm_pkg::RST_BYTE;
        run_q[c] <= 1'b0;
        ie_q[c]  <= 1'b0;
      end else begin
        if (md_wr) md_q[c] <= wdat_q;
        if (wr_ctrl) begin
          run_q[c] <= wdat_q[RUN_B];
          ie_q[c]  <= wdat_q[IE_B];
        end
      end
    end

    // writing one leaves the flag alone; a set in the clear cycle wins
    always_ff @(posedge clk_sys) begin
      if (!resetn) begin
        flag_q[c] <= 1'b0;
      end else begin
        flag_q[c] <= zero[c]
                  || (flag_q[c] && !(wr_ctrl && !wdat_q[FLAG_B])); // RQ3 RQ4 RQ18
      end
    end

    always_ff @(posedge clk_sys) begin
      if (!resetn || !run_q[c]) begin
        wave_q[c] <= 1'b1; // RQ17
      end else if (md_q[c] == dbm_pkg::BYTE_MAX) begin
        wave_q[c] <= 1'b0;
      end else if (tick[c]) begin
        if (pwm[c]) begin
          if (ovf[c]) wave_q[c] <= 1'b0; // RQ17
          else if (match[c]) wave_q[c] <= 1'b1;
        end else if (match[c]) begin
          wave_q[c] <= !wave_q[c]; // RQ17
        end
      end
    end
  end

  assign low_wave_out  = wave_q[0];
  assign high_wave_out = wave_q[1];

  // =====================================================
  // interrupts
  logic irq_q;
  logic vreq_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      stat_q <= 2'h0;
      irq_q  <= 1'b0;
      vreq_q <= 1'b0;
    end else begin
      stat_q <= zero | (stat_q & ~(wr_iclr ? wdat_q[1:0] : 2'h0));
      irq_q  <= |(stat_q & ien_q);
      vreq_q <= (flag_q[1] && ie_q[1]) || (flag_q[0] && ie_q[0]); // RQ1 RQ2
    end
  end

  assign match_irq_req = vreq_q;
  assign irq           = irq_q;

  // =====================================================
  // read channel
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (s_axi_araddr[17:2])
      dbm_pkg::IDX_CTRL:  rd_byte = {run_q[1], run_q[0], casc_q, omode_q,
                                     flag_q[1], ie_q[1], flag_q[0], ie_q[0]};
      dbm_pkg::IDX_PRESC: rd_byte = presc_q;
      dbm_pkg::IDX_LCNT:  rd_byte = cnt_q[0];
      dbm_pkg::IDX_HCNT:  rd_byte = cnt_q[1];
      dbm_pkg::IDX_LMD:   rd_byte = md_q[0];
      dbm_pkg::IDX_HMD:   rd_byte = md_q[1];
      dbm_pkg::IDX_ISTAT: rd_byte = {6'h00, stat_q};
      dbm_pkg::IDX_ICLR:  rd_byte = 8'h00;
      dbm_pkg::IDX_IEN:   rd_byte = {6'h00, ien_q};
      default:            rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= dbm_pkg::RESP_OKAY;
      arready_q <= 1'b0;
    end else begin
      if (ar_hs) begin
        rvalid_q <= 1'b1;
        rdata_q  <= {24'h000000, rd_byte};
        rresp_q  <= rd_hit ? dbm_pkg::RESP_OKAY : dbm_pkg::RESP_SLV;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
      arready_q <= !(ar_hs || (rvalid_q && !s_axi_rready));
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // =====================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  vreq_high_a: assert property (flag_q[1] && ie_q[1] |=> match_irq_req) // RQ1
    else $error("high vector request missing");
  vreq_low_a: assert property (flag_q[0] && ie_q[0] |=> match_irq_req) // RQ2
    else $error("low vector request missing");
  low_flag_a: assert property (zero[0] |=> flag_q[0]) // RQ3
    else $error("low flag not set at zero");
  high_flag_a: assert property (zero[1] |=> flag_q[1]) // RQ18
    else $error("high flag not set at zero");
  flag_keep_a: assert property (flag_q[0] && !wr_ctrl |=> flag_q[0]) // RQ4
    else $error("low flag lost without clear");
  presc_hold_a: assert property (run_q[0] && !zero[0] |=> $stable(act_q[0])) // RQ5
    else $error("prescale changed mid period");
  div_one_a: assert property (run_q[0] && !act_q[0][3] |-> tick[0]) // RQ7
    else $error("low prescaler not dividing by one");
  div_two_a: assert property (
    run_q[1] && !casc_q && act_q[1] == 4'h8 && tick[1] |=> !tick[1]) // RQ6
    else $error("high prescaler not dividing by two");
  low_inc_a: assert property (
    tick[0] && !match[0] |=> cnt_q[0] == $past(cnt_q[0]) + 8'h01) // RQ8
    else $error("low counter step wrong");
  high_inc_a: assert property (
    run_q[1] && !tick[1] && $past(run_q[1]) |=> $stable(cnt_q[1])) // RQ9
    else $error("high counter moved without pulse");
  low_buf_a: assert property (!run_q[0] |=> mbuf_q[0] == $past(md_q[0])) // RQ11
    else $error("low buffer not following data");
  high_buf_a: assert property (!run_q[1] |=> mbuf_q[1] == $past(md_q[1])) // RQ13
    else $error("high buffer not following data");
  match_rst_a: assert property (
    tick[0] && match[0] && !omode_q |=> cnt_q[0] == 8'h00) // RQ16 RQ10
    else $error("low counter not reset on match");
  high_rst_a: assert property (
    tick[1] && match[1] && casc_q |=> cnt_q[1] == 8'h00) // RQ16 RQ12
    else $error("high counter not reset on match");
  stop_zero_a: assert property (!run_q[1] |=> cnt_q[1] == 8'h00) // RQ14
    else $error("stopped counter not zero");
  cascade_a: assert property (casc_q && tick[1] |-> zero[0]) // RQ15
    else $error("cascade advanced off low period");
  wave_stop_a: assert property (!run_q[0] |=> low_wave_out) // RQ17
    else $error("low output not high while stopped");

  low_zero_c: cover property (zero[0]);
  cascade_c: cover property (casc_q && tick[1]);
  pwm_c: cover property (omode_q && ovf[0]);
  irq_c: cover property (irq);
endmodule

/* verification/dbm_timer_tb_top.sv */
// self-checking testbench for the dual byte match timer
`timescale 1ns/1ps
`define CHK(nm, got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("unexpected %s: expected %0h seen %0h", nm, exp, got); \
    end \
  end
module dbm_timer_tb_top;
  logic        clk_sys = 1'b0;
  logic        resetn  = 1'b0;
  logic [17:0] awaddr  = 18'h00000;
  logic [17:0] araddr  = 18'h00000;
  logic [31:0] wdata   = 32'h00000000;
  logic [3:0]  wstrb   = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        lo_out, hi_out, mreq, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  logic [33:0] mon_r;
  logic [1:0]  mon_b;
  logic [31:0] v;
  int          n_mismatch = 0;
  int          checked    = 0;
  int          seed;
  int          n;

  always #10 clk_sys = ~clk_sys;

  dbm_timer #(.ADDR_W(18)) i_dbm_timer (
    .clk_sys(clk_sys), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .low_wave_out(lo_out),
    .high_wave_out(hi_out), .match_irq_req(mreq), .irq(irq)
  );

  // =====================================================
  // response watcher: oldest note against each answer
  always @(posedge clk_sys) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      mon_r = exp_r.pop_front();
      `CHK("read answer", {rresp, rdata}, mon_r)
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      mon_b = exp_b.pop_front();
      `CHK("write answer", bresp, mon_b)
    end
  end

  // =====================================================
  // bus tasks; the leading edge keeps releases and raises apart
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
    int k;
    k = 0;
    @(posedge clk_sys);
    exp_b.push_back(er);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h000000, d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 100);
    bready <= 1'b0;
    // a write answer that never comes is a failure, not a skip
    if (bvalid !== 1'b1) n_mismatch++;
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
    int k;
    k = 0;
    @(posedge clk_sys);
    exp_r.push_back({er, 24'h000000, d});
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 100);
    rready <= 1'b0;
    if (rvalid !== 1'b1) n_mismatch++;
  endtask

  // cycles until the chosen wave output next changes
  task automatic wait_chg(input bit ch, output int k);
    logic s;
    s = ch ? hi_out : lo_out;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while ((ch ? hi_out : lo_out) === s && k < 2000);
  endtask

  task automatic per_run(input bit ch, input logic [3:0] nib, input logic [7:0] ctl, input int e);
    int k;
    wr(dbm_pkg::IDX_CTRL, 8'h00);
    wr(dbm_pkg::IDX_PRESC, ch ? {nib, 4'h0} : {4'h0, nib});
    wr(dbm_pkg::IDX_LMD, 8'h01);
    wr(dbm_pkg::IDX_HMD, 8'h01);
    wr(dbm_pkg::IDX_CTRL, ctl);
    wait_chg(ch, k);
    wait_chg(ch, k);
    `CHK("half period", k, e)
  endtask

  task automatic flag_run(input bit ch);
    logic [7:0] run, flg, ie, st;
    run = ch ? 8'h80 : 8'h40;
    flg = ch ? 8'h08 : 8'h02;
    ie  = ch ? 8'h04 : 8'h01;
    st  = ch ? 8'h02 : 8'h01;
    wr(dbm_pkg::IDX_LMD, 8'h03);
    wr(dbm_pkg::IDX_HMD, 8'h03);
    wr(dbm_pkg::IDX_PRESC, 8'h00);
    wr(dbm_pkg::IDX_IEN, 8'h03);
    wr(dbm_pkg::IDX_CTRL, run | ie);
    repeat (20) @(posedge clk_sys);
    `CHK("match request", mreq, 1'b1)
    // stop first so no zero event can race the flag clear
    wr(dbm_pkg::IDX_CTRL, flg | ie);
    rd(dbm_pkg::IDX_CTRL, flg | ie);
    rd(ch ? dbm_pkg::IDX_HCNT : dbm_pkg::IDX_LCNT, 8'h00);
    `CHK("stopped output", ch ? hi_out : lo_out, 1'b1)
    wr(dbm_pkg::IDX_CTRL, ie);
    rd(dbm_pkg::IDX_CTRL, ie);
    repeat (3) @(posedge clk_sys);
    `CHK("match request", mreq, 1'b0)
    rd(dbm_pkg::IDX_ISTAT, st);
    `CHK("irq", irq, 1'b1)
    wr(dbm_pkg::IDX_IEN, 8'h00);
    repeat (3) @(posedge clk_sys);
    `CHK("irq masked", irq, 1'b0)
    wr(dbm_pkg::IDX_IEN, 8'h03);
    repeat (3) @(posedge clk_sys);
    `CHK("irq", irq, 1'b1)
    wr(dbm_pkg::IDX_ICLR, st);
    repeat (3) @(posedge clk_sys);
    `CHK("irq cleared", irq, 1'b0)
    rd(dbm_pkg::IDX_ISTAT, 8'h00);
    $display("test done: flags channel %0d", ch);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // =====================================================
  // main sequence
  initial begin
    seed = 32'hAE81F8AB;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    `CHK("wave outputs", {lo_out, hi_out}, 2'b11)
    rd(dbm_pkg::IDX_CTRL, 8'h00);
    rd(dbm_pkg::IDX_PRESC, 8'h00);
    rd(dbm_pkg::IDX_LCNT, 8'h00);
    rd(dbm_pkg::IDX_HCNT, 8'h00);
    rd(dbm_pkg::IDX_LMD, 8'h00);
    rd(dbm_pkg::IDX_HMD, 8'h00);
    rd(dbm_pkg::IDX_ISTAT, 8'h00);
    rd(dbm_pkg::IDX_IEN, 8'h00);
    $display("test done: reset values");
    repeat (4) begin
      v = $random(seed);
      wr(dbm_pkg::IDX_LMD, v[7:0]);
      wr(dbm_pkg::IDX_HMD, v[15:8]);
      wr(dbm_pkg::IDX_PRESC, v[23:16]);
      rd(dbm_pkg::IDX_LMD, v[7:0]);
      rd(dbm_pkg::IDX_HMD, v[15:8]);
      rd(dbm_pkg::IDX_PRESC, v[23:16]);
    end
    wr(dbm_pkg::IDX_LCNT, 8'h5A);
    rd(dbm_pkg::IDX_LCNT, 8'h00);
    wr(dbm_pkg::IDX_HCNT, 8'hA5);
    rd(dbm_pkg::IDX_HCNT, 8'h00);
    rd(dbm_pkg::IDX_ICLR, 8'h00);
    wr(16'hFE1E, 8'hA5, dbm_pkg::RESP_SLV);
    rd(16'hFE1E, 8'h00, dbm_pkg::RESP_SLV);
    $display("test done: register access");
    flag_run(1'b0);
    flag_run(1'b1);
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 9; c++) begin
        per_run(ch[0], (c == 8) ? 4'h0 : (4'h8 | c[3:0]), ch ? 8'h80 : 8'h40,
                (c == 8) ? 2 : (4 << c));
      end
    end
    per_run(1'b1, 4'h0, 8'hE0, 4);
    // pwm: low from overflow to match is two ticks, high the rest of 256
    per_run(1'b0, 4'h0, 8'h50, 2);
    wait_chg(1'b0, n);
    `CHK("pwm high time", n, 254)
    wr(dbm_pkg::IDX_LMD, 8'hFF);
    repeat (2) @(posedge clk_sys);
    `CHK("full match output", lo_out, 1'b0)
    $display("test done: prescale and cascade periods");
    // a new prescale must wait for the next reload
    wr(dbm_pkg::IDX_CTRL, 8'h00);
    wr(dbm_pkg::IDX_PRESC, 8'h00);
    wr(dbm_pkg::IDX_LMD, 8'h40);
    wr(dbm_pkg::IDX_CTRL, 8'h40);
    wait_chg(1'b0, n);
    wr(dbm_pkg::IDX_PRESC, 8'h0F);
    wait_chg(1'b0, n);
    `CHK("deferred prescale", n < 70, 1'b1)
    $display("test done: deferred prescale");
    // reset while the low channel still runs
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    `CHK("wave outputs", {lo_out, hi_out}, 2'b11)
    rd(dbm_pkg::IDX_CTRL, 8'h00);
    rd(dbm_pkg::IDX_LCNT, 8'h00);
    rd(dbm_pkg::IDX_LMD, 8'h00);
    rd(dbm_pkg::IDX_PRESC, 8'h00);
    rd(dbm_pkg::IDX_ISTAT, 8'h00);
    $display("test done: reset while running");
    repeat (2) @(posedge clk_sys);
    wrap_up();
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    wrap_up();
  end
endmodule
